// ==== adcf_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - amplitude refresh once per drive cycle at 0, twice at 1
// - in mode 3 the input pin is pwm at 0, analog at 1
// - pwm input scales amplitude by measured duty cycle
// - analog input sets amplitude from the input sample
// - fixed-frequency drive at 1 except with analog input in mode 3, resonance tracking at 0
// - fixed drive with pwm input commutates at pwm rate over 128
// - other modes take fixed frequency from the seven-bit period
// - two-bit window 100, 200, 300, 390 us minimum detect time
// - calibration field defaults 2; code 0 lasts 150 to 350 ms
// - codes 1 to 3 last 250-450, 500-700, 1000-1200 ms
// - status bit reads 1 once nonvolatile memory is programmed
// - writing program bit copies 0x16 to 0x1A once per reset
module adcf_top #(
    parameter logic [6:0] DEV_ADDR  = 7'h2C, // arbitrary bus address
    parameter int         ZC_CYC_0  = adcf_pkg::ZC_CYC_0,
    parameter int         ZC_CYC_1  = adcf_pkg::ZC_CYC_1,
    parameter int         ZC_CYC_2  = adcf_pkg::ZC_CYC_2,
    parameter int         ZC_CYC_3  = adcf_pkg::ZC_CYC_3,
    parameter int         CAL_CYC_0 = adcf_pkg::CAL_CYC_0,
    parameter int         CAL_CYC_1 = adcf_pkg::CAL_CYC_1,
    parameter int         CAL_CYC_2 = adcf_pkg::CAL_CYC_2,
    parameter int         CAL_CYC_3 = adcf_pkg::CAL_CYC_3
) (
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output var  logic       sda_o,
    output var  logic       sda_oe_o,
    input  wire logic       input_trigger_pin_i,
    input  wire logic       zero_cross_i,
    input  wire logic [7:0] amp_sample_i,
    input  wire logic [7:0] engine_amp_i,
    input  wire logic       cal_start_i,
    output var  logic       drive_phase_o,
    output var  logic [7:0] drive_amp_o,
    output var  logic       amp_update_o,
    output var  logic       cal_busy_o,
    output var  logic       nvm_wr_o,
    output var  logic [7:0] nvm_addr_o
);
    import adcf_pkg::*;

    typedef struct packed {
        logic         scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
        adcf_bus_st_t st;
        logic [3:0]   bitcnt;
        logic [7:0]   shift, ptr;
        logic         rw, nack, sda_oe, sda_out;
        logic [2:0]   mode;
        logic         rate, analog, fixed;
        logic [1:0]   zc, cal;
        logic [6:0]   period;
        logic         otp_done, prog_busy, nvm_wr;
        logic [2:0]   prog_idx;
        logic [7:0]   nvm_addr;
    } adcf_top_st_t;

    adcf_top_st_t r, n;
    logic         rise, fall, start, stop;
    logic [7:0]   rd_byte;

    // register read decode, reserved bits zero
    function automatic logic [7:0] read_reg(input logic [7:0] a,
                                            input adcf_top_st_t s);
        logic [7:0] d;
        d = 8'h00;
        if (a == REG_MODE) begin
            d[2:0] = s.mode;
        end else if (a == REG_CTL3) begin
            d[CTL3_RATE_BIT]   = s.rate;
            d[CTL3_ANALOG_BIT] = s.analog;
            d[CTL3_FIXED_BIT]  = s.fixed;
        end else if (a == REG_CTL4) begin
            d[CTL4_ZC_LSB +: 2]  = s.zc;
            d[CTL4_CAL_LSB +: 2] = s.cal;
            d[CTL4_STAT_BIT]     = s.otp_done;
            d[CTL4_PROG_BIT]     = s.prog_busy;
        end else if (a == REG_PERIOD) begin
            d[6:0] = s.period;
        end
        return d;
    endfunction

    // bus line events from the synchronised copies
    assign rise    = r.scl_s && !r.scl_p;
    assign fall    = !r.scl_s && r.scl_p;
    assign start   = r.scl_s && r.scl_p && r.sda_p && !r.sda_s;
    assign stop    = r.scl_s && r.scl_p && !r.sda_p && r.sda_s;
    assign rd_byte = read_reg(r.ptr, r);

    // bus slave, register writes and memory copy sequencer
    always_comb begin
        n = r;
        n.scl_m  = scl_i;
        n.scl_s  = r.scl_m;
        n.scl_p  = r.scl_s;
        n.sda_m  = sda_i;
        n.sda_s  = r.sda_m;
        n.sda_p  = r.sda_s;
        n.nvm_wr = 1'b0;
        // one register copied per cycle, then locked until reset
        if (r.prog_busy) begin
            n.nvm_wr   = 1'b1;
            n.nvm_addr = NVM_FIRST + {5'h00, r.prog_idx};
            n.prog_idx = r.prog_idx + 3'h1;
            if (n.nvm_addr == NVM_LAST) begin
                n.prog_busy = 1'b0;
                n.otp_done  = 1'b1;
            end
        end
        if (start) begin
            n.st     = ST_ADDR;
            n.bitcnt = 4'h0;
            n.sda_oe = 1'b0;
        end else if (stop) begin
            n.st     = ST_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            case (r.st)
                ST_ADDR, ST_REG, ST_WR: begin
                    if (rise) begin
                        n.shift  = {r.shift[6:0], r.sda_s};
                        n.bitcnt = r.bitcnt + 4'h1;
                    end else if (fall && r.bitcnt == 4'h8) begin
                        n.sda_oe = 1'b1;
                        if (r.st == ST_ADDR) begin
                            if (r.shift[7:1] == DEV_ADDR) begin
                                n.rw = r.shift[0];
                                n.st = ST_ADDR_ACK;
                            end else begin
                                n.sda_oe = 1'b0;
                                n.st     = ST_IDLE;
                            end
                        end else if (r.st == ST_REG) begin
                            n.ptr = r.shift;
                            n.st  = ST_REG_ACK;
                        end else begin
                            n.ptr = r.ptr + 8'h01;
                            n.st  = ST_WR_ACK;
                            if (r.ptr == REG_MODE) begin
                                n.mode = r.shift[2:0];
                            end else if (r.ptr == REG_CTL3) begin
                                n.rate   = r.shift[CTL3_RATE_BIT];
                                n.analog = r.shift[CTL3_ANALOG_BIT];
                                n.fixed  = r.shift[CTL3_FIXED_BIT];
                            end else if (r.ptr == REG_CTL4) begin
                                n.zc  = r.shift[CTL4_ZC_LSB +: 2];
                                n.cal = r.shift[CTL4_CAL_LSB +: 2];
                                if (r.shift[CTL4_PROG_BIT] && !r.otp_done
                                    && !r.prog_busy) begin
                                    n.prog_busy = 1'b1;
                                    n.prog_idx  = 3'h0;
                                end
                            end else if (r.ptr == REG_PERIOD) begin
                                n.period = r.shift[6:0];
                            end
                        end
                    end
                end
                ST_ADDR_ACK, ST_RD_ACK: begin
                    if (rise && r.st == ST_RD_ACK) begin
                        n.nack = r.sda_s;
                    end else if (fall) begin
                        n.bitcnt = 4'h0;
                        if ((r.st == ST_ADDR_ACK && r.rw)
                            || (r.st == ST_RD_ACK && !r.nack)) begin
                            n.shift  = rd_byte;
                            n.ptr    = r.ptr + 8'h01;
                            n.sda_oe = !rd_byte[7];
                            n.st     = ST_RD;
                        end else begin
                            n.sda_oe = 1'b0;
                            n.st     = (r.st == ST_RD_ACK) ? ST_IDLE : ST_REG;
                        end
                    end
                end
                ST_REG_ACK, ST_WR_ACK: begin
                    if (fall) begin
                        n.sda_oe = 1'b0;
                        n.bitcnt = 4'h0;
                        n.st     = ST_WR;
                    end
                end
                ST_RD: begin
                    if (fall) begin
                        n.bitcnt = r.bitcnt + 4'h1;
                        n.shift  = {r.shift[6:0], 1'b0};
                        if (r.bitcnt == 4'h7) begin
                            n.sda_oe = 1'b0;
                            n.st     = ST_RD_ACK;
                        end else begin
                            n.sda_oe = !r.shift[6];
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // state register with documented reset values
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            r        <= '0;
            r.st     <= ST_IDLE;
            r.scl_m  <= 1'b1;
            r.scl_s  <= 1'b1;
            r.scl_p  <= 1'b1;
            r.sda_m  <= 1'b1;
            r.sda_s  <= 1'b1;
            r.sda_p  <= 1'b1;
            r.mode   <= MODE_RST;
            r.rate   <= RATE_RST;
            r.analog <= ANALOG_RST;
            r.fixed  <= FIXED_RST;
            r.zc     <= ZC_RST;
            r.cal    <= CAL_RST;
            r.period <= PERIOD_RST;
        end else begin
            r <= n;
        end
    end

    // configuration to the drive engine
    adcf_cfg_if cfg ();
    assign cfg.mode    = r.mode;
    assign cfg.rate    = r.rate;
    assign cfg.analog  = r.analog;
    assign cfg.fixed   = r.fixed;
    assign cfg.zc_sel  = r.zc;
    assign cfg.cal_sel = r.cal;
    assign cfg.period  = r.period;

    adcf_drive #(
        .ZC_CYC_0  (ZC_CYC_0),
        .ZC_CYC_1  (ZC_CYC_1),
        .ZC_CYC_2  (ZC_CYC_2),
        .ZC_CYC_3  (ZC_CYC_3),
        .CAL_CYC_0 (CAL_CYC_0),
        .CAL_CYC_1 (CAL_CYC_1),
        .CAL_CYC_2 (CAL_CYC_2),
        .CAL_CYC_3 (CAL_CYC_3)
    ) u_drive (
        .core_clk_i   (core_clk_i),
        .reset_i      (reset_i),
        .cfg          (cfg),
        .trig_pin_i   (input_trigger_pin_i),
        .zero_cross_i (zero_cross_i),
        .amp_sample_i (amp_sample_i),
        .engine_amp_i (engine_amp_i),
        .cal_start_i  (cal_start_i),
        .phase_o      (drive_phase_o),
        .amp_o        (drive_amp_o),
        .upd_o        (amp_update_o),
        .cal_busy_o   (cal_busy_o)
    );

    assign sda_o      = r.sda_out;
    assign sda_oe_o   = r.sda_oe;
    assign nvm_wr_o   = r.nvm_wr;
    assign nvm_addr_o = r.nvm_addr;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    otp_last_a: assert property (
        $rose(r.otp_done) |-> nvm_wr_o && nvm_addr_o == NVM_LAST)
        else $error("status set before last copy");
    otp_once_a: assert property (
        r.otp_done && $past(r.otp_done) |-> !nvm_wr_o && !r.prog_busy)
        else $error("memory copy after programming");
    nvm_burst_a: assert property (
        $rose(nvm_wr_o) |-> nvm_addr_o == NVM_FIRST ##1 nvm_wr_o [*4])
        else $error("copy burst not five registers");
    resv_zero_a: assert property (
        rd_byte[7:3] == 5'h00 || r.ptr == REG_CTL4 || r.ptr == REG_PERIOD)
        else $error("reserved bits read nonzero");

    otp_done_c:  cover property ($rose(r.otp_done));
    bus_read_c:  cover property (r.st == ST_RD_ACK && fall && !r.nack);
endmodule
`default_nettype wire

// ==== adcf_pkg.sv ====
package adcf_pkg;
    // clock rate used to turn times into cycle counts
    localparam int CLK_KHZ = 20_000;

    // register byte addresses on the two-wire bus
    localparam logic [7:0] REG_MODE   = 8'h01;
    localparam logic [7:0] REG_CTL3   = 8'h1D;
    localparam logic [7:0] REG_CTL4   = 8'h1E;
    localparam logic [7:0] REG_PERIOD = 8'h20;
    localparam logic [7:0] NVM_FIRST  = 8'h16;
    localparam logic [7:0] NVM_LAST   = 8'h1A;

    // field positions
    localparam int CTL3_RATE_BIT   = 2;
    localparam int CTL3_ANALOG_BIT = 1;
    localparam int CTL3_FIXED_BIT  = 0;
    localparam int CTL4_ZC_LSB     = 6;
    localparam int CTL4_CAL_LSB    = 4;
    localparam int CTL4_STAT_BIT   = 2;
    localparam int CTL4_PROG_BIT   = 0;

    // reset values
    localparam logic [2:0] MODE_RST   = 3'h0;
    localparam logic       RATE_RST   = 1'h0;
    localparam logic       ANALOG_RST = 1'h0;
    localparam logic       FIXED_RST  = 1'h0;
    localparam logic [1:0] ZC_RST     = 2'h0;
    localparam logic [1:0] CAL_RST    = 2'h2;
    localparam logic [6:0] PERIOD_RST = 7'h00;

    // operating mode that reads the input/trigger pin
    localparam logic [2:0] MODE_EXT_INPUT = 3'h3;

    // pwm input divider and duty measurement window
    localparam int         PWM_DIV        = 128;
    localparam int         PWM_HALF_EDGES = PWM_DIV / 2;
    localparam logic [7:0] PWM_WIN_LAST   = 8'hFE;

    // zero-crossing minimum windows, least time so rounded up
    localparam int ZC_US_0  = 100;
    localparam int ZC_US_1  = 200;
    localparam int ZC_US_2  = 300;
    localparam int ZC_US_3  = 390;
    localparam int ZC_CYC_0 = (ZC_US_0 * CLK_KHZ + 999) / 1000;
    localparam int ZC_CYC_1 = (ZC_US_1 * CLK_KHZ + 999) / 1000;
    localparam int ZC_CYC_2 = (ZC_US_2 * CLK_KHZ + 999) / 1000;
    localparam int ZC_CYC_3 = (ZC_US_3 * CLK_KHZ + 999) / 1000;

    // calibration lengths, the minimum of each range
    localparam int CAL_MS_0  = 150;
    localparam int CAL_MS_1  = 250;
    localparam int CAL_MS_2  = 500;
    localparam int CAL_MS_3  = 1000;
    localparam int CAL_CYC_0 = CAL_MS_0 * CLK_KHZ;
    localparam int CAL_CYC_1 = CAL_MS_1 * CLK_KHZ;
    localparam int CAL_CYC_2 = CAL_MS_2 * CLK_KHZ;
    localparam int CAL_CYC_3 = CAL_MS_3 * CLK_KHZ;

    // clock cycles per unit of the fixed drive period field
    localparam int PERIOD_UNIT_CYC = 100;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
        ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
    } adcf_bus_st_t;
endpackage

// ==== adcf_cfg_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface adcf_cfg_if;
    logic [2:0] mode;
    logic       rate;
    logic       analog;
    logic       fixed;
    logic [1:0] zc_sel;
    logic [1:0] cal_sel;
    logic [6:0] period;
    modport ctl (output mode, rate, analog, fixed, zc_sel, cal_sel, period);
    modport drv (input mode, rate, analog, fixed, zc_sel, cal_sel, period);
endinterface
`default_nettype wire

// ==== adcf_drive.sv ====
`timescale 1ns/10ps
`default_nettype none
module adcf_drive #(
    parameter int ZC_CYC_0        = adcf_pkg::ZC_CYC_0,
    parameter int ZC_CYC_1        = adcf_pkg::ZC_CYC_1,
    parameter int ZC_CYC_2        = adcf_pkg::ZC_CYC_2,
    parameter int ZC_CYC_3        = adcf_pkg::ZC_CYC_3,
    parameter int CAL_CYC_0       = adcf_pkg::CAL_CYC_0,
    parameter int CAL_CYC_1       = adcf_pkg::CAL_CYC_1,
    parameter int CAL_CYC_2       = adcf_pkg::CAL_CYC_2,
    parameter int CAL_CYC_3       = adcf_pkg::CAL_CYC_3,
    parameter int PERIOD_UNIT_CYC = adcf_pkg::PERIOD_UNIT_CYC
) (
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    adcf_cfg_if.drv         cfg,
    input  wire logic       trig_pin_i,
    input  wire logic       zero_cross_i,
    input  wire logic [7:0] amp_sample_i,
    input  wire logic [7:0] engine_amp_i,
    input  wire logic       cal_start_i,
    output var  logic       phase_o,
    output var  logic [7:0] amp_o,
    output var  logic       upd_o,
    output var  logic       cal_busy_o
);
    import adcf_pkg::*;

    typedef struct packed {
        logic        in_m, in_s, in_p, zc_m, zc_s, zc_p;
        logic [7:0]  win_cnt, hi_cnt, pwm_amp;
        logic [5:0]  edge_cnt;
        logic [15:0] half_cnt;
        logic [12:0] zc_cnt;
        logic [24:0] cal_cnt;
        logic        cal_busy, phase, upd;
        logic [7:0]  amp;
    } adcf_drv_st_t;

    adcf_drv_st_t r, n;
    logic         ext, pwm_in, fixed_ok, in_rise, zc_edge;
    logic         edge_tog, timer_tog, zc_tog, tog;
    logic [15:0]  half_lim;
    logic [12:0]  zc_lim;
    logic [24:0]  cal_lim;
    logic [7:0]   src_amp;

    // mode decode and commutation events
    assign ext       = (cfg.mode == MODE_EXT_INPUT);
    assign pwm_in    = ext && !cfg.analog;
    assign fixed_ok  = cfg.fixed && !(ext && cfg.analog);
    assign in_rise   = r.in_s && !r.in_p;
    assign zc_edge   = r.zc_s ^ r.zc_p;
    assign half_lim  = 16'(cfg.period) * 16'(PERIOD_UNIT_CYC);
    assign edge_tog  = in_rise
                    && (r.edge_cnt == 6'(PWM_HALF_EDGES - 1));
    assign timer_tog = (half_lim != 16'h0000)
                    && (r.half_cnt >= half_lim - 16'h0001);
    assign zc_tog    = zc_edge && (r.zc_cnt >= zc_lim);
    assign tog       = fixed_ok ? (ext ? edge_tog : timer_tog)
                                : zc_tog;

    // window and calibration length select
    always_comb begin
        case (cfg.zc_sel)
            2'h0: zc_lim = 13'(ZC_CYC_0);
            2'h1: zc_lim = 13'(ZC_CYC_1);
            2'h2: zc_lim = 13'(ZC_CYC_2);
            default: zc_lim = 13'(ZC_CYC_3);
        endcase
        case (cfg.cal_sel)
            2'h0: cal_lim = 25'(CAL_CYC_0);
            2'h1: cal_lim = 25'(CAL_CYC_1);
            2'h2: cal_lim = 25'(CAL_CYC_2);
            default: cal_lim = 25'(CAL_CYC_3);
        endcase
    end

    // amplitude source per input mode
    assign src_amp = !ext ? engine_amp_i
                   : (cfg.analog ? amp_sample_i
                                 : r.pwm_amp);

    // next state
    always_comb begin
        n = r;
        n.in_m = trig_pin_i;
        n.in_s = r.in_m;
        n.in_p = r.in_s;
        n.zc_m = zero_cross_i;
        n.zc_s = r.zc_m;
        n.zc_p = r.zc_s;
        n.upd  = 1'b0;
        // duty measured as high cycles over a 255-cycle window
        if (r.win_cnt == PWM_WIN_LAST) begin
            n.pwm_amp = r.hi_cnt + {7'h00, r.in_s};
            n.win_cnt = 8'h00;
            n.hi_cnt  = 8'h00;
        end else begin
            n.win_cnt = r.win_cnt + 8'h01;
            n.hi_cnt  = r.hi_cnt + {7'h00, r.in_s};
        end
        if (in_rise) begin
            n.edge_cnt = r.edge_cnt + 6'h01;
        end
        n.half_cnt = r.half_cnt + 16'h0001;
        if (r.zc_cnt != 13'h1FFF) begin
            n.zc_cnt = r.zc_cnt + 13'h0001;
        end
        if (tog) begin
            n.phase    = !r.phase;
            n.half_cnt = 16'h0000;
            n.zc_cnt   = 13'h0000;
            // once per cycle updates only on the rising half
            if (cfg.rate || !r.phase) begin
                n.amp = src_amp;
                n.upd = 1'b1;
            end
        end
        if (!fixed_ok || !pwm_in) begin
            n.edge_cnt = 6'h00;
        end
        // calibration timer
        if (!r.cal_busy && cal_start_i) begin
            n.cal_busy = 1'b1;
            n.cal_cnt  = cal_lim - 25'h0000001;
        end else if (r.cal_busy) begin
            if (r.cal_cnt == 25'h0000000) begin
                n.cal_busy = 1'b0;
            end else begin
                n.cal_cnt = r.cal_cnt - 25'h0000001;
            end
        end
    end

    // state register
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign phase_o    = r.phase;
    assign amp_o      = r.amp;
    assign upd_o      = r.upd;
    assign cal_busy_o = r.cal_busy;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    pwm_divide_a: assert property (
        (tog && fixed_ok && pwm_in) |-> (r.edge_cnt == 6'h3F) && in_rise)
        else $error("pwm commutation not at 64th edge");
    update_rate_a: assert property (
        $rose(upd_o) && !$past(cfg.rate) |-> phase_o)
        else $error("once-per-cycle update on wrong half");
    amp_pwm_a: assert property (
        upd_o && $past(pwm_in) |-> amp_o == $past(r.pwm_amp))
        else $error("pwm amplitude not from duty");
    amp_analog_a: assert property (
        upd_o && $past(ext) && $past(cfg.analog)
        |-> amp_o == $past(amp_sample_i))
        else $error("analog amplitude not from sample");
    zc_window_a: assert property (
        $changed(phase_o) && !$past(fixed_ok)
        |-> $past(r.zc_cnt) >= $past(zc_lim))
        else $error("zero crossing taken inside window");
    fixed_period_a: assert property (
        $changed(phase_o) && $past(fixed_ok) && !$past(ext)
        |-> $past(r.half_cnt) == $past(half_lim) - 16'h0001)
        else $error("fixed period half wrong");
    cal_length_a: assert property (
        $rose(cal_busy_o) |-> cal_busy_o [*8])
        else $error("calibration ended early");

    pwm_fixed_c: cover property (tog && fixed_ok && pwm_in);
    twice_upd_c: cover property (upd_o && cfg.rate && !phase_o);
    cal_done_c:  cover property ($fell(cal_busy_o));
endmodule
`default_nettype wire

// ==== adcf_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module adcf_host #(
    parameter logic [6:0] ADDR = 7'h2C
) (
    input  wire logic core_clk_i,
    input  wire logic sda_oe_i,
    output var  logic scl_o,
    output var  logic sda_o
);
    logic rel;
    // pulled-up data line, low while either party pulls it
    assign sda_o = rel & ~sda_oe_i;
    // bus idles high
    initial begin
        rel = 1'b1;
        scl_o = 1'b1;
    end
    // half a bus period of 8 core clocks, slow enough for the synchronisers
    task automatic half();
        repeat (8) @(negedge core_clk_i);
    endtask
    // data moves one clock after scl falls, never while scl is high
    task automatic bit_io(input logic b, output logic r);
        @(negedge core_clk_i);
        rel = b;
        half();
        scl_o = 1'b1;
        half();
        r = sda_o;
        scl_o = 1'b0;
    endtask
    task automatic start();
        rel = 1'b1;
        half();
        scl_o = 1'b1;
        half();
        rel = 1'b0;
        half();
        scl_o = 1'b0;
    endtask
    task automatic stop();
        @(negedge core_clk_i);
        rel = 1'b0;
        half();
        scl_o = 1'b1;
        half();
        rel = 1'b1;
        half();
    endtask
    // one byte msb first, ninth bit released (ack seen, or nack on reads)
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(1'b1, a);
    endtask
    task automatic write_reg(input logic [7:0] ra, input logic [7:0] wd);
        logic [7:0] q;
        start();
        xfer({ADDR, 1'b0}, q);
        xfer(ra, q);
        xfer(wd, q);
        stop();
    endtask
    task automatic read_reg(input logic [7:0] ra, output logic [7:0] q);
        start();
        xfer({ADDR, 1'b0}, q);
        xfer(ra, q);
        start();
        xfer({ADDR, 1'b1}, q);
        xfer(8'hFF, q);
        stop();
    endtask
endmodule
`default_nettype wire

// ==== test_actuator_drive_control_fields.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_actuator_drive_control_fields;
    import adcf_pkg::*;
    typedef struct {
        logic [7:0] ra;
        logic [7:0] wd;
        logic [7:0] ex;
    } adcf_row_t;
    logic       core_clk, reset, scl, sda, sda_oe, zc, cal_start, cal_busy;
    logic       nvm_wr, trig, trig_hi, pwm_run, phase, ph, upd;
    logic [7:0] amp_s, amp, nvm_addr, q, last_addr, eng_amp;
    int         err_total, tests_run, cycles, n, nvm_cnt, upd_cnt;
    adcf_row_t  rows[7];
    adcf_top #(.ZC_CYC_0(4), .ZC_CYC_1(8), .CAL_CYC_3(50)
    ) i_dut (.core_clk_i(core_clk), .reset_i(reset), .scl_i(scl),
        .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
        .input_trigger_pin_i(trig),
        .zero_cross_i(zc), .amp_sample_i(amp_s), .engine_amp_i(eng_amp),
        .cal_start_i(cal_start), .drive_phase_o(phase), .drive_amp_o(amp),
        .amp_update_o(upd), .cal_busy_o(cal_busy), .nvm_wr_o(nvm_wr),
        .nvm_addr_o(nvm_addr));
    adcf_host i_host (.core_clk_i(core_clk), .sda_oe_i(sda_oe), .scl_o(scl),
        .sda_o(sda));
    task automatic check(input string nm, input logic [7:0] s, e);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // clock of 50 ns
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // strobe tallies off the launching edge, pwm pin source, run ceiling
    always @(negedge core_clk) begin
        cycles++;
        if (nvm_wr === 1'b1) begin
            nvm_cnt++;
            last_addr = nvm_addr;
        end
        if (upd === 1'b1) begin
            upd_cnt++;
        end
        // two-cycle pwm, so a half drive cycle is 128 clocks
        trig <= pwm_run ? ~trig : trig_hi;
        if (cycles == 60000) begin
            err_total++;
            results();
        end
    end
    // register rows, then calibration, amplitude, copy and reset
    initial begin
        rows = '{'{REG_CTL3, 8'hFF, 8'h07},
            '{REG_CTL3, 8'h02, 8'h02},
            '{REG_PERIOD, 8'hFF, 8'h7F},
            '{REG_CTL4, 8'hCA, 8'hC0},
            '{REG_CTL4, 8'h70, 8'h70},
            '{8'h30, 8'h55, 8'h00},
            '{REG_MODE, 8'h03, 8'h03}};
        reset = 1'b1;
        zc = 1'b0;
        cal_start = 1'b0;
        amp_s = 8'h00;
        trig_hi = 1'b0;
        pwm_run = 1'b0;
        eng_amp = 8'h33;
        repeat (8) @(negedge core_clk);
        reset = 1'b0;
        repeat (4) @(negedge core_clk);
        foreach (rows[i]) begin
            i_host.write_reg(rows[i].ra, rows[i].wd);
            i_host.read_reg(rows[i].ra, q);
            check("reg", q, rows[i].ex);
        end
        $display("register rows done");
        cal_start = 1'b1;
        @(negedge core_clk);
        cal_start = 1'b0;
        n = 0;
        while (cal_busy === 1'b1 && n < 100) begin
            n++;
            @(negedge core_clk);
        end
        check("cal", 8'(n), 8'h32);
        $display("calibration done");
        amp_s = 8'h5A;
        trig_hi = 1'b1;
        repeat (4) begin
            repeat (40) @(negedge core_clk);
            zc = ~zc;
        end
        repeat (10) @(negedge core_clk);
        check("amp", amp, 8'h5A);
        $display("analog amplitude done");
        // pin held high: full duty, one refresh per drive cycle
        i_host.write_reg(REG_CTL3, 8'h00);
        n = upd_cnt;
        repeat (2) begin
            repeat (40) @(negedge core_clk);
            zc = ~zc;
        end
        repeat (10) @(negedge core_clk);
        check("pwm amp", amp, 8'hFF);
        check("upd once", 8'(upd_cnt - n), 8'h01);
        $display("pwm amplitude done");
        // fixed drive from a running pwm, twice-per-cycle refresh
        pwm_run = 1'b1;
        i_host.write_reg(REG_CTL3, 8'h05);
        for (int k = 0; k < 2; k++) begin
            ph = phase;
            n = 0;
            while (phase === ph && n < 400) begin
                n++;
                @(negedge core_clk);
            end
        end
        check("half", 8'(n), 8'(PWM_DIV));
        pwm_run = 1'b0;
        trig_hi = 1'b0;
        $display("fixed pwm drive done");
        i_host.write_reg(REG_CTL4, 8'h71);
        i_host.read_reg(REG_CTL4, q);
        check("ctl4", q, 8'h74);
        check("copies", 8'(nvm_cnt), 8'h05);
        check("last", last_addr, NVM_LAST);
        i_host.write_reg(REG_CTL4, 8'h71);
        check("once", 8'(nvm_cnt), 8'h05);
        $display("memory copy done");
        reset = 1'b1;
        repeat (8) @(negedge core_clk);
        reset = 1'b0;
        repeat (4) @(negedge core_clk);
        i_host.read_reg(REG_CTL4, q);
        check("rst", q, 8'h20);
        // mode 0 after reset: amplitude from the playback engine
        repeat (40) @(negedge core_clk);
        zc = ~zc;
        repeat (10) @(negedge core_clk);
        check("engine amp", amp, eng_amp);
        $display("second reset done");
        results();
    end
endmodule
`default_nettype wire
